// [design/trace_pkg.sv]
package trace_pkg;

    // ------------------------------------------------------------------
    // Register port map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_TB_READ = 4'h2;

    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_PROF_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_TX_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_CNT_LSB = 8;

    localparam logic [15:0] TB_BUSY_CODE = 16'heeee;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Trace line layout
    // ------------------------------------------------------------------
    localparam int LINE_BYTES = 8;
    localparam int LINE_W = 64;
    localparam int START_BYTES = 4;
    localparam int DIRECT_BITS = 32;
    localparam int TS_W = 16;
    localparam logic [15:0] TS_MAX = 16'hffff;
    localparam int PENDING_LIMIT = 64;

    typedef enum logic [2:0] {
        START_LINE_LAYOUT = 3'b000,
        INDIRECT_BRANCH_LAYOUT = 3'b001,
        DIRECT_ONLY_LAYOUT = 3'b010,
        VECTOR_LINE_LAYOUT = 3'b011,
        TIMESTAMP_ONLY_LAYOUT = 3'b100
    } layout_t;

    // Flag positions inside the line format byte.
    localparam int TERM_FLAG_BIT = 4;
    localparam int BUF_OVF_FLAG_BIT = 5;
    localparam int TS_OVF_FLAG_BIT = 6;

endpackage : trace_pkg

// [design/line_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface line_if;
    logic line_valid;
    logic line_ready;
    logic line_done;
    logic [63:0] line_data;

    modport store
    (
        output line_valid,
        output line_data,
        input line_ready,
        input line_done
    );

    modport sender
    (
        input line_valid,
        input line_data,
        output line_ready,
        output line_done
    );
endinterface : line_if

`default_nettype wire

// [design/line_sender.sv]
`timescale 1ns/1ps
`default_nettype none

module line_sender
    import trace_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    line_if.sender lines,
    output logic [7:0] tool_byte,
    output logic tool_byte_valid,
    input wire logic tool_byte_ready
);

    typedef enum logic {
        SEND_IDLE = 1'b0,
        SEND_BUSY = 1'b1
    } send_state_t;

    send_state_t state_q;
    logic [LINE_W-1:0] shift_q;
    logic [2:0] idx_q;
    logic [2:0] last_q;
    logic take;
    logic accept;
    logic is_last;

    assign take = (state_q == SEND_IDLE) && lines.line_valid;
    assign accept = (state_q == SEND_BUSY) && tool_byte_ready;
    assign is_last = (idx_q == last_q);
    assign lines.line_ready = (state_q == SEND_IDLE);
    assign lines.line_done = accept && is_last;
    assign tool_byte = shift_q[7:0];
    assign tool_byte_valid = (state_q == SEND_BUSY);

    // ------------------------------------------------------------------
    // Byte serialiser
    // ------------------------------------------------------------------
    // Byte 0 is the format byte, so it always leaves first.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_q <= SEND_IDLE;
            shift_q <= '0;
            idx_q <= 3'h0;
            last_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                SEND_IDLE:
                begin
                    if (take)
                    begin
                        state_q <= SEND_BUSY;
                        shift_q <= lines.line_data;
                        idx_q <= 3'h0;
                        // A start line carries only four bytes.
                        if (lines.line_data[2:0] == START_LINE_LAYOUT)
                            last_q <= 3'(START_BYTES - 1);
                        else
                            last_q <= 3'(LINE_BYTES - 1);
                    end
                end
                SEND_BUSY:
                begin
                    if (accept)
                    begin
                        if (is_last)
                            state_q <= SEND_IDLE;
                        shift_q <= {8'h00, shift_q[LINE_W-1:8]};
                        idx_q <= idx_q + 3'h1;
                    end
                end
                default:
                    state_q <= SEND_IDLE;
            endcase
        end
    end

endmodule : line_sender

`default_nettype wire

// [design/code_profiling_trace_packer.sv]
// What this block does
// - Disarmed while sending: writes dropped, port reads 0xEEEE.
// - First entry is four-byte start line.
// - Lines are eight bytes, byte zero format.
// - Direct branch bits packed into bytes one-four.
// - Direct branches stored compressed, no addresses.
// - Indexed jump closes line, 24-bit target upper.
// - Interrupt closes line with vector and timestamp; dropped if an indexed jump coincides.
// - Timestamp counter clears on every line write.
// - Vector byte is vector address bits eight-one.
// - Pointer advances after start and each closed line.
// - 65536 idle cycles write timestamp overflow entry.
// - 64 pending lines: overflow entry, stop, disarm.
// - Disarm during profiling writes termination entry.
// - Final entry timestamp-only unless event coincides.
// - Format byte sent first; tool decodes layout.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module code_profiling_trace_packer
    import trace_pkg::*;
#(
    parameter int DEPTH = 128
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [trace_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [trace_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [trace_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [23:0] pc_start,
    input wire logic direct_cof_valid,
    input wire logic direct_cof_taken,
    input wire logic jump_valid,
    input wire logic [23:0] jump_target,
    input wire logic irq_valid,
    input wire logic [8:0] irq_vector_addr,
    output logic [7:0] tool_byte,
    output logic tool_byte_valid,
    input wire logic tool_byte_ready,
    output logic debug_armed,
    output logic profiling_active
);
    import trace_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic arm_q;
    logic prof_en_q;
    logic active_q;
    logic ovf_seen_q;
    logic [PTR_W:0] wr_ptr_q;
    logic [PTR_W:0] rd_ptr_q;
    logic [DIRECT_BITS-1:0] direct_q;
    logic [5:0] dcnt_q;
    logic [TS_W-1:0] ts_q;
    logic [DATA_W-1:0] rdata_q;
    logic [LINE_W-1:0] mem [DEPTH];

    logic [PTR_W:0] pending;
    logic transmitting;
    logic write_ok;
    logic start_go;

    // Line assembly results.
    logic line_wr;
    logic line_final;
    logic line_ovf;
    logic [LINE_W-1:0] line_word;
    logic [DIRECT_BITS-1:0] dir_ins;
    logic [5:0] dcnt_ins;

    line_if lines ();

    // ------------------------------------------------------------------
    // Occupancy
    // ------------------------------------------------------------------
    // Only lines not yet fully sent count towards overflow.
    assign pending = wr_ptr_q - rd_ptr_q;
    assign transmitting = (pending != '0);
    assign lines.line_valid = transmitting;
    assign lines.line_data = mem[rd_ptr_q[PTR_W-1:0]];

    assign debug_armed = arm_q;
    assign profiling_active = active_q;
    assign reg_rdata = rdata_q;

    // Register writes are dropped while the last lines drain.
    assign write_ok = reg_we && !(!arm_q && transmitting);

    // Profiling starts once armed with profiling selected; a new run
    // waits until the previous run has drained, so its lines stay in order.
    assign start_go = arm_q && prof_en_q && !active_q && !transmitting;

    // ------------------------------------------------------------------
    // Line assembly
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] line_format_byte;
        logic [7:0] vec_byte;
        logic end_req;
        logic ovf_req;
        logic ts_ovf;
        layout_t layout;
        line_format_byte = 8'h00;
        vec_byte = 8'h00;
        end_req = 1'b0;
        ovf_req = 1'b0;
        ts_ovf = 1'b0;
        layout = TIMESTAMP_ONLY_LAYOUT;
        line_wr = 1'b0;
        line_final = 1'b0;
        line_ovf = 1'b0;
        line_word = '0;

        // Each branch outcome is a single bit; no address is kept.
        dir_ins = direct_q;
        dcnt_ins = dcnt_q;
        if (direct_cof_valid && (dcnt_q < 6'(DIRECT_BITS)))
        begin
            dir_ins[dcnt_q[4:0]] = direct_cof_taken;
            dcnt_ins = dcnt_q + 6'h1;
        end

        if (start_go)
        begin
            // Start entry: format byte then three-byte start PC.
            line_wr = 1'b1;
            line_word = {32'h0000_0000, pc_start, 5'h00, START_LINE_LAYOUT};
        end
        else if (active_q)
        begin
            ovf_req = (pending == (PTR_W + 1)'(PENDING_LIMIT));
            end_req = !arm_q || ovf_req;
            ts_ovf = (ts_q == TS_MAX);
            // Coinciding events choose the layout, else timestamp-only.
            if (jump_valid)
            begin
                layout = INDIRECT_BRANCH_LAYOUT;
                line_wr = 1'b1;
            end
            else if (irq_valid)
            begin
                layout = VECTOR_LINE_LAYOUT;
                vec_byte = irq_vector_addr[8:1];
                line_wr = 1'b1;
            end
            else if ((dcnt_ins == 6'(DIRECT_BITS)) || (end_req && direct_cof_valid))
            begin
                layout = DIRECT_ONLY_LAYOUT;
                line_wr = 1'b1;
            end
            else if (end_req || ts_ovf)
            begin
                layout = TIMESTAMP_ONLY_LAYOUT;
                line_wr = 1'b1;
            end

            line_format_byte[2:0] = layout;
            line_format_byte[TS_OVF_FLAG_BIT] = ts_ovf && line_wr;
            line_format_byte[BUF_OVF_FLAG_BIT] = ovf_req;
            line_format_byte[TERM_FLAG_BIT] = end_req;
            line_final = end_req && line_wr;
            line_ovf = ovf_req && line_wr;

            // Direct bits always occupy bytes one to four.
            case (layout)
                INDIRECT_BRANCH_LAYOUT:
                    line_word = {jump_target, dir_ins, line_format_byte};
                VECTOR_LINE_LAYOUT:
                    line_word = {ts_q, vec_byte, dir_ins, line_format_byte};
                DIRECT_ONLY_LAYOUT:
                    line_word = {16'h0000, 8'h00, dir_ins, line_format_byte};
                default:
                    line_word = {ts_q, 8'h00, dir_ins, line_format_byte};
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Trace buffer storage
    // ------------------------------------------------------------------
    // The buffer holds more than the overflow limit, so the final entry
    // written at the limit always has room.
    always_ff @(posedge sys_clk)
    begin
        if (line_wr)
            mem[wr_ptr_q[PTR_W-1:0]] <= line_word;
    end

    // Write pointer advances once per stored line.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            wr_ptr_q <= '0;
        else if (line_wr)
            wr_ptr_q <= wr_ptr_q + (PTR_W + 1)'(1);
    end

    // Read pointer advances only when the last byte has been taken.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            rd_ptr_q <= '0;
        else if (lines.line_done)
            rd_ptr_q <= rd_ptr_q + (PTR_W + 1)'(1);
    end

    // ------------------------------------------------------------------
    // Direct branch accumulator
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            direct_q <= '0;
            dcnt_q <= 6'h00;
        end
        else if (line_wr || !active_q)
        begin
            // A closed line takes the accumulated bits with it.
            direct_q <= '0;
            dcnt_q <= 6'h00;
        end
        else
        begin
            direct_q <= dir_ins;
            dcnt_q <= dcnt_ins;
        end
    end

    // ------------------------------------------------------------------
    // Cycle timestamp
    // ------------------------------------------------------------------
    // Wrapping from all ones coincides with the overflow entry, which
    // clears the counter anyway.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            ts_q <= '0;
        else if (line_wr || !active_q)
            ts_q <= '0;
        else
            ts_q <= ts_q + 16'h0001;
    end

    // ------------------------------------------------------------------
    // Profiling run control
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            active_q <= 1'b0;
        else if (start_go)
            active_q <= 1'b1;
        else if (line_final)
            active_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            ovf_seen_q <= 1'b0;
        else if (line_ovf)
            ovf_seen_q <= 1'b1;
        else if (start_go)
            ovf_seen_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Overflow disarms in hardware and wins over a write in the same cycle.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            arm_q <= 1'b0;
            prof_en_q <= 1'b0;
        end
        else if (line_ovf)
            arm_q <= 1'b0;
        else if (write_ok && (reg_addr == REG_CTRL))
        begin
            arm_q <= reg_wdata[CTRL_ARM_BIT];
            prof_en_q <= reg_wdata[CTRL_PROF_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            rdata_q <= REG_RESET;
        else if (!reg_re)
            rdata_q <= REG_RESET;
        else if (reg_addr == REG_CTRL)
        begin
            rdata_q <= REG_RESET;
            rdata_q[CTRL_ARM_BIT] <= arm_q;
            rdata_q[CTRL_PROF_BIT] <= prof_en_q;
        end
        else if (reg_addr == REG_STATUS)
        begin
            rdata_q <= REG_RESET;
            rdata_q[STAT_ACTIVE_BIT] <= active_q;
            rdata_q[STAT_TX_BIT] <= transmitting;
            rdata_q[STAT_OVF_BIT] <= ovf_seen_q;
            rdata_q[STAT_CNT_LSB +: PTR_W + 1] <= pending;
        end
        else if (reg_addr == REG_TB_READ)
        begin
            if (!arm_q && transmitting)
                rdata_q <= TB_BUSY_CODE;
            else if (transmitting)
                rdata_q <= lines.line_data[15:0];
            else
                rdata_q <= REG_RESET;
        end
        else
            rdata_q <= REG_RESET;
    end

    // ------------------------------------------------------------------
    // Line transmission
    // ------------------------------------------------------------------
    line_sender u_sender
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .lines(lines),
        .tool_byte(tool_byte),
        .tool_byte_valid(tool_byte_valid),
        .tool_byte_ready(tool_byte_ready)
    );

endmodule : code_profiling_trace_packer

`default_nettype wire

// [testbench/code_profiling_trace_packer_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module code_profiling_trace_packer_monitor
#(
    parameter int DEPTH = 128
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_re,
    input wire logic [15:0] reg_rdata,
    input wire logic [7:0] tool_byte,
    input wire logic tool_byte_valid,
    input wire logic tool_byte_ready,
    input wire logic debug_armed,
    input wire logic profiling_active
);
    // ----------------------------------------
    // Line byte counting
    // ----------------------------------------
    logic [3:0] cnt_q;
    logic [3:0] len_q;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !tool_byte_valid)
            cnt_q <= 4'h0;
        else if (tool_byte_ready)
            cnt_q <= cnt_q + 4'h1;
    end

    // The length is taken from the format byte, so a bad count shows the sender not sending the length its own layout code gives.
    always_ff @(posedge sys_clk)
    begin
        if (tool_byte_valid && cnt_q == 4'h0)
            len_q <= (tool_byte[2:0] == 3'h0) ? 4'h4 : 4'h8;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    AST_RDATA_IDLE: assert property (!$past(reg_re) |-> reg_rdata == 16'h0000)
        else $error("read data outside its answer cycle");
    AST_BYTE_HOLD: assert property (tool_byte_valid && !tool_byte_ready |=>
        tool_byte_valid && $stable(tool_byte))
        else $error("offered byte changed before acceptance");
    AST_FMT_FIRST: assert property ($rose(tool_byte_valid) |->
        tool_byte[2:0] <= 3'h4 && !tool_byte[3] && !tool_byte[7])
        else $error("line does not open with a format byte");
    AST_START_LINE: assert property ($rose(profiling_active) |->
        ##[1:2] tool_byte_valid && tool_byte == 8'h00)
        else $error("run does not open with a start line");
    AST_START_ARMED: assert property ($rose(profiling_active) |->
        debug_armed && $past(debug_armed))
        else $error("profiling started while disarmed");
    AST_DISARM_STOP: assert property ($fell(debug_armed) |=> !profiling_active)
        else $error("profiling kept running after disarm");
    AST_LINE_LEN: assert property ($fell(tool_byte_valid) |-> cnt_q == len_q)
        else $error("line byte count wrong");
    AST_IDLE_GAP: assert property (tool_byte_valid && tool_byte_ready &&
        cnt_q == len_q - 4'h1 && cnt_q != 4'h0 |=> !tool_byte_valid)
        else $error("no idle cycle after a line");

    COV_START: cover property ($rose(profiling_active));
    COV_STALL: cover property (tool_byte_valid && !tool_byte_ready [*4]);
    COV_DISARM: cover property ($fell(debug_armed) && profiling_active);
endmodule : code_profiling_trace_packer_monitor

bind code_profiling_trace_packer code_profiling_trace_packer_monitor #(.DEPTH(DEPTH)) mon_u
(
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .reg_re(reg_re),
    .reg_rdata(reg_rdata),
    .tool_byte(tool_byte),
    .tool_byte_valid(tool_byte_valid),
    .tool_byte_ready(tool_byte_ready),
    .debug_armed(debug_armed),
    .profiling_active(profiling_active)
);

`default_nettype wire

// [testbench/trace_tool_model.sv]
`timescale 1ns/1ps
`default_nettype none

module trace_tool_model
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] tool_byte,
    input wire logic tool_byte_valid,
    output logic tool_byte_ready,
    input wire logic stall,
    input wire logic slow
);
    logic [63:0] lines [$];
    logic [63:0] acc;
    int cnt = 0;
    int len = 8;

    // Slow mode accepts every other cycle, so the sender must hold bytes.
    always @(posedge sys_clk)
    begin
        if (!reset_n)
            tool_byte_ready <= 1'b0;
        else
            tool_byte_ready <= !stall && !(slow && tool_byte_ready);
        if (reset_n && tool_byte_valid && tool_byte_ready)
        begin
            if (cnt == 0)
            begin
                acc = 64'h0;
                len = (tool_byte[2:0] == 3'h0) ? 4 : 8;
            end
            acc[cnt*8 +: 8] = tool_byte;
            cnt++;
            if (cnt == len)
            begin
                lines.push_back(acc);
                cnt = 0;
            end
        end
    end
endmodule : trace_tool_model

`default_nettype wire

// [testbench/code_profiling_trace_packer_test.sv]
`timescale 1ns/1ps
`default_nettype none

module code_profiling_trace_packer_test;
    import trace_pkg::*;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [15:0] reg_rdata;
    logic [23:0] pc_start = 24'h123456;
    logic direct_cof_valid = 1'b0;
    logic direct_cof_taken = 1'b0;
    logic jump_valid = 1'b0;
    logic [23:0] jump_target = 24'habcdef;
    logic irq_valid = 1'b0;
    logic [8:0] irq_vector_addr = 9'h1a4;
    logic [7:0] tool_byte;
    logic tool_byte_valid;
    logic tool_byte_ready;
    logic debug_armed;
    logic profiling_active;
    logic stall = 1'b0;
    logic slow = 1'b1;
    int mismatches = 0;
    int n_compared = 0;
    logic [15:0] v;
    logic [15:0] ts;
    logic [3:0] adr [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
    // Expected lines of the first run beside the mask of bytes that are fixed.
    logic [63:0] exp_l [6] = '{64'h12345600, 64'hffff000000000044, 64'habcdef0000000501,
        64'hd20000000003, 64'hc3a55a3c02, 64'h14};
    logic [63:0] msk [6] = '{'1, '1, '1, 64'hffffffffffff, '1, 64'hffffffffffff};

    always #12.5 sys_clk = ~sys_clk;

    code_profiling_trace_packer #(.DEPTH(128)) dut_u
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_we(reg_we),
        .reg_re(reg_re),
        .reg_rdata(reg_rdata),
        .pc_start(pc_start),
        .direct_cof_valid(direct_cof_valid),
        .direct_cof_taken(direct_cof_taken),
        .jump_valid(jump_valid),
        .jump_target(jump_target),
        .irq_valid(irq_valid),
        .irq_vector_addr(irq_vector_addr),
        .tool_byte(tool_byte),
        .tool_byte_valid(tool_byte_valid),
        .tool_byte_ready(tool_byte_ready),
        .debug_armed(debug_armed),
        .profiling_active(profiling_active)
    );

    trace_tool_model tool_u
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tool_byte(tool_byte),
        .tool_byte_valid(tool_byte_valid),
        .tool_byte_ready(tool_byte_ready),
        .stall(stall),
        .slow(slow)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk64

    task automatic final_report();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic dirs(input logic [31:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            direct_cof_valid <= 1'b1;
            direct_cof_taken <= b[i];
        end
        @(posedge sys_clk);
        direct_cof_valid <= 1'b0;
    endtask : dirs

    task automatic pulse(input logic jump);
        @(posedge sys_clk);
        jump_valid <= jump;
        irq_valid <= !jump;
        @(posedge sys_clk);
        jump_valid <= 1'b0;
        irq_valid <= 1'b0;
    endtask : pulse

    task automatic drain();
        for (int i = 0; i < 3000; i++)
        begin
            rd(REG_STATUS, v);
            if (v[STAT_TX_BIT] === 1'b0)
                break;
        end
    endtask : drain

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        tick(12);
        reset_n <= 1'b1;
        foreach (adr[i])
        begin
            rd(adr[i], v);
            chk16(v, REG_RESET);
        end
        wr(REG_CTRL, 16'h0003);
        tick(65600);
        dirs(32'h5, 3);
        pulse(1'b1);
        tick(18);
        pulse(1'b0);
        dirs(32'hc3a55a3c, 32);
        tick(60);
        stall <= 1'b1;
        wr(REG_CTRL, 16'h0000);
        tick(3);
        rd(REG_TB_READ, v);
        chk16(v, TB_BUSY_CODE);
        wr(REG_CTRL, 16'h0003);
        rd(REG_CTRL, v);
        chk16(v, 16'h0000);
        rd(REG_STATUS, v);
        chk16(v, 16'h0102);
        stall <= 1'b0;
        drain();
        chk16(16'(tool_u.lines.size()), 16'h0006);
        foreach (exp_l[i])
            chk64(tool_u.lines[i] & msk[i], exp_l[i]);
        // Jump accepted 20 edges before the interrupt; the exact count edge is open by one.
        ts = tool_u.lines[3][63:48];
        chk16({15'h0, ts >= 16'd19 && ts <= 16'd21}, 16'h0001);
        stall <= 1'b1;
        wr(REG_CTRL, 16'h0003);
        rd(REG_TB_READ, v);
        chk16(v, {pc_start[7:0], 8'h00});
        for (int i = 0; i < 70; i++)
            pulse(1'b1);
        tick(4);
        chk16({15'h0, debug_armed}, 16'h0000);
        rd(REG_STATUS, v);
        chk16({13'h0, v[2:0]}, 16'h0006);
        stall <= 1'b0;
        drain();
        chk16({13'h0, tool_u.lines[$][6:4]}, 16'h0003);
        final_report();
    end

    initial
    begin
        tick(90000);
        mismatches++;
        final_report();
    end
endmodule : code_profiling_trace_packer_test

`default_nettype wire
